// File: hpw_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module hpw_host_port (
  input wire logic REF_CLK, // 25 MHz clock.
  input wire logic RST_N, // Synchronous reset, active low.
  input wire logic CE, // Clock enable; all state frozen while low.
  input wire logic CARD_SELECT_N, // Card select from host, active low.
  input wire logic READ_STROBE_N, // Read strobe from host, active low.
  input wire logic WRITE_STROBE_N, // Write strobe from host, active low.
  input wire logic [2:0] REGISTER_SELECT_LINES, // Task register address.
  input wire logic [7:0] HOST_DATA_BUS_IN, // Data bus level from host.
  output logic [7:0] HOST_DATA_BUS_OUT, // Read data toward host.
  output logic HOST_DATA_BUS_OE, // High while the port drives the bus.
  output logic WAIT_N, // Wait toward host, active low.
  output logic COMMAND_DONE_IRQ, // Interrupt request, active high.
  output logic BUFFER_TRANSFER_REQUEST, // Data request, active high.
  output hpw_pkg::hpw_task_t TASK, // Task file toward the core.
  output hpw_pkg::hpw_core_req_t CORE_REQ, // Requests toward the core.
  input wire hpw_pkg::hpw_core_rsp_t CORE_RSP // Answers from the core.
);
  import hpw_pkg::*;

  typedef enum logic [1:0] {HPW_IDLE, HPW_BUSY, HPW_HOLD} hpw_state_t;

  logic cs_meta, rd_meta, wr_meta;
  logic cs_sync, rd_sync, wr_sync;
  hpw_state_t state;
  logic is_read;
  logic [2:0] adr;
  logic [7:0] wdata;
  logic [7:0] wait_cnt;
  logic [7:0] cmd_win;
  logic core_done;
  logic access_start;
  logic access_end;
  logic [7:0] next_rdata;

  // Two-stage synchronisers; only the second stage feeds any decision.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cs_meta <= 1'b0;
      rd_meta <= 1'b0;
      wr_meta <= 1'b0;
      cs_sync <= 1'b0;
      rd_sync <= 1'b0;
      wr_sync <= 1'b0;
    end else if (CE) begin
      cs_meta <= !CARD_SELECT_N;
      rd_meta <= !READ_STROBE_N;
      wr_meta <= !WRITE_STROBE_N;
      cs_sync <= cs_meta;
      rd_sync <= rd_meta;
      wr_sync <= wr_meta;
    end
  end

  // An access begins once per select assertion, since the host must
  // release select between bytes.
  assign access_start = CE && state == HPW_IDLE && cs_sync &&
                        (rd_sync || wr_sync);
  assign access_end = CE && state == HPW_BUSY && wait_cnt == 8'h00 &&
                      core_done;

  // Access sequencer.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state <= HPW_IDLE;
    end else if (CE) begin
      case (state)
        HPW_IDLE: begin
          if (access_start) begin
            state <= HPW_BUSY;
          end
        end
        HPW_BUSY: begin
          if (access_end) begin
            state <= HPW_HOLD;
          end
        end
        HPW_HOLD: begin
          if (!cs_sync) begin
            state <= HPW_IDLE;
          end
        end
        default: state <= HPW_IDLE;
      endcase
    end
  end

  // Address, direction and write byte are caught at the start; the host
  // keeps them steady while wait is low, so one sample suffices.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      is_read <= 1'b0;
      adr <= ADR_DATA;
      wdata <= RST_ZERO;
    end else if (access_start) begin
      is_read <= rd_sync;
      adr <= REGISTER_SELECT_LINES;
      wdata <= HOST_DATA_BUS_IN;
    end
  end

  // Wait length: the short minimum, or the long one for the first access
  // inside the window after a command.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      wait_cnt <= 8'h00;
    end else if (CE) begin
      if (access_start) begin
        wait_cnt <= (cmd_win != 8'h00) ? WAIT_LONG_CYC :
                    WAIT_MIN_CYC;
      end else if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
    end
  end

  // Window after a command write in which one long wait is allowed.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cmd_win <= 8'h00;
    end else if (CE) begin
      if (access_end && !is_read && adr == ADR_STATUS_CMD) begin
        cmd_win <= CMD_WINDOW_CYC;
      end else if (access_start) begin
        cmd_win <= 8'h00;
      end else if (cmd_win != 8'h00) begin
        cmd_win <= cmd_win - 8'h01;
      end
    end
  end

  // Data register accesses finish only when the core has the byte ready
  // or has taken it; every other register answers at once.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      core_done <= 1'b0;
    end else if (CE) begin
      if (access_start) begin
        core_done <= REGISTER_SELECT_LINES != ADR_DATA;
      end else if (state == HPW_BUSY && !core_done) begin
        core_done <= is_read ? CORE_RSP.rd_valid :
                     CORE_RSP.wr_ack;
      end
    end
  end

  // The synchroniser makes every access longer than 100 ns, so wait is
  // always used; it rises only when the access has truly completed.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      WAIT_N <= 1'b1;
    end else if (CE) begin
      if (access_start) begin
        WAIT_N <= 1'b0;
      end else if (access_end) begin
        WAIT_N <= 1'b1;
      end
    end
  end

  // Read multiplexer over the task file.
  always_comb begin
    case (adr)
      ADR_DATA: next_rdata = CORE_RSP.rd_data;
      ADR_ERR_PRECOMP: next_rdata = CORE_RSP.error;
      ADR_SEC_COUNT: next_rdata = TASK.sec_count;
      ADR_SEC_NUMBER: next_rdata = TASK.sec_number;
      ADR_CYL_LOW: next_rdata = TASK.cyl_low;
      ADR_CYL_HIGH: next_rdata = TASK.cyl_high;
      ADR_SIZE_DRIVE_HEAD: next_rdata = TASK.size_drive_head;
      default: next_rdata = CORE_RSP.status;
    endcase
  end

  // Read data is latched at read completion and held until the next read completes.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      HOST_DATA_BUS_OUT <= RST_ZERO;
    end else if (access_end && is_read) begin
      HOST_DATA_BUS_OUT <= next_rdata;
    end
  end

  // The bus is driven straight from the pins so it floats the moment
  // select goes away, without synchroniser lag.
  assign HOST_DATA_BUS_OE = !CARD_SELECT_N && !READ_STROBE_N;

  // Task file writes.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      TASK.precomp <= RST_PRECOMP;
      TASK.sec_count <= RST_SEC_COUNT;
      TASK.sec_number <= RST_ZERO;
      TASK.cyl_low <= RST_ZERO;
      TASK.cyl_high <= RST_ZERO;
      TASK.size_drive_head <= RST_ZERO;
    end else if (access_end && !is_read) begin
      case (adr)
        ADR_ERR_PRECOMP: TASK.precomp <= wdata;
        ADR_SEC_COUNT: TASK.sec_count <= wdata;
        ADR_SEC_NUMBER: TASK.sec_number <= wdata;
        ADR_CYL_LOW: TASK.cyl_low <= wdata;
        ADR_CYL_HIGH: TASK.cyl_high <= wdata;
        ADR_SIZE_DRIVE_HEAD: TASK.size_drive_head <= wdata;
        default: ;
      endcase
    end
  end

  // Core strobes: one-cycle pulses, plus a read request level held while
  // a data read waits for its byte.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      CORE_REQ <= '0;
    end else if (CE) begin
      CORE_REQ.cmd_strobe <= access_end && !is_read &&
                             adr == ADR_STATUS_CMD;
      CORE_REQ.wr_strobe <= access_start && wr_sync &&
                            REGISTER_SELECT_LINES == ADR_DATA;
      CORE_REQ.rd_req <= (access_start && rd_sync &&
                          REGISTER_SELECT_LINES == ADR_DATA) ||
                         (CORE_REQ.rd_req && !CORE_RSP.rd_valid);
      if (access_start) begin
        CORE_REQ.wr_data <= HOST_DATA_BUS_IN;
        CORE_REQ.cmd <= HOST_DATA_BUS_IN;
      end
    end
  end

  // Interrupt flag; a completion in the clearing cycle wins.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      COMMAND_DONE_IRQ <= 1'b0;
    end else if (CE) begin
      if (CORE_RSP.cmd_done) begin
        COMMAND_DONE_IRQ <= 1'b1;
      end else if (access_end && adr == ADR_STATUS_CMD) begin
        COMMAND_DONE_IRQ <= 1'b0;
      end
    end
  end

  // Transfer request: set per buffered byte, cleared by each data or
  // cylinder-low access; a new byte in the clearing cycle wins.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      BUFFER_TRANSFER_REQUEST <= 1'b0;
    end else if (CE) begin
      if (CORE_RSP.buf_next) begin
        BUFFER_TRANSFER_REQUEST <= 1'b1;
      end else if (access_end && (adr == ADR_DATA || adr == ADR_CYL_LOW)) begin
        BUFFER_TRANSFER_REQUEST <= 1'b0;
      end
    end
  end

endmodule : hpw_host_port
`default_nettype wire

// File: hpw_pkg.sv
// What this block does
// - Hold wait until read byte is fetched
// - Hold wait until written byte is taken
// - Wait on every access; none finishes within 100 ns
// - Assert wait until data ready
// - Wait lasts 750 ns up to 6 us; data-register waits have no upper limit and end only when the core answers
// - Long waits only right after a command
// - Eight data, three address, seven control lines
// - Address picks one of eight task registers
// - Select toggles per byte; bus floats otherwise
// - Transfer request while buffer ready; cleared on data or cylinder-low access
package hpw_pkg;

  // Task file register addresses.
  localparam logic [2:0] ADR_DATA = 3'h0;
  localparam logic [2:0] ADR_ERR_PRECOMP = 3'h1;
  localparam logic [2:0] ADR_SEC_COUNT = 3'h2;
  localparam logic [2:0] ADR_SEC_NUMBER = 3'h3;
  localparam logic [2:0] ADR_CYL_LOW = 3'h4;
  localparam logic [2:0] ADR_CYL_HIGH = 3'h5;
  localparam logic [2:0] ADR_SIZE_DRIVE_HEAD = 3'h6;
  localparam logic [2:0] ADR_STATUS_CMD = 3'h7;

  // Values after reset.
  localparam logic [7:0] RST_SEC_COUNT = 8'h01;
  localparam logic [7:0] RST_PRECOMP = 8'h80;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Timing, in nanoseconds, and the cycle counts derived at 25 MHz.
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAIT_MIN_NS = 750;
  localparam int WAIT_LONG_NS = 6000;
  localparam int CMD_WINDOW_NS = 6000;
  localparam logic [7:0] WAIT_MIN_CYC =
    8'((WAIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WAIT_LONG_CYC = 8'(WAIT_LONG_NS / CLK_PERIOD_NS);
  localparam logic [7:0] CMD_WINDOW_CYC = 8'(CMD_WINDOW_NS / CLK_PERIOD_NS);

  // Task file contents as seen by the controller core.
  typedef struct packed {
    logic [7:0] precomp;
    logic [7:0] sec_count;
    logic [7:0] sec_number;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic [7:0] size_drive_head;
  } hpw_task_t;

  // Requests toward the controller core.
  typedef struct packed {
    logic cmd_strobe;
    logic [7:0] cmd;
    logic rd_req;
    logic wr_strobe;
    logic [7:0] wr_data;
  } hpw_core_req_t;

  // Answers from the controller core.
  typedef struct packed {
    logic rd_valid;
    logic [7:0] rd_data;
    logic wr_ack;
    logic [7:0] status;
    logic [7:0] error;
    logic cmd_done;
    logic buf_next;
  } hpw_core_rsp_t;

endpackage : hpw_pkg

// File: hpw_host_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hpw_host_port_assertions (
  input wire logic REF_CLK, // Clock.
  input wire logic RST_N, // Reset, active low.
  input wire logic CE, // Clock enable.
  input wire logic CARD_SELECT_N, // Select.
  input wire logic READ_STROBE_N, // Read strobe.
  input wire logic HOST_DATA_BUS_OE, // Bus enable.
  input wire logic WAIT_N, // Wait.
  input wire logic COMMAND_DONE_IRQ, // Interrupt.
  input wire logic BUFFER_TRANSFER_REQUEST, // Data request.
  input wire hpw_pkg::hpw_core_req_t CORE_REQ, // Core requests.
  input wire hpw_pkg::hpw_core_rsp_t CORE_RSP // Core answers.
);
  import hpw_pkg::*;
  logic [7:0] wcnt;
  logic wr_pend;
  // Wait length so far; waits past 255 cycles would wrap unnoticed.
  always_ff @(posedge REF_CLK) begin
    wcnt <= (!RST_N || WAIT_N) ? 8'h00 : wcnt + 8'h01;
  end
  // A written data byte not yet taken by the core.
  always_ff @(posedge REF_CLK) begin
    wr_pend <= RST_N && !CORE_RSP.wr_ack && (wr_pend || CORE_REQ.wr_strobe);
  end
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence wait_begin;
    $fell(WAIT_N);
  endsequence
  sequence wait_end;
    $rose(WAIT_N) && $past(RST_N);
  endsequence
  AST_BUS_EN: assert property (
    HOST_DATA_BUS_OE == (!CARD_SELECT_N && !READ_STROBE_N))
    else $error("bus enable wrong");
  AST_WAIT_MIN: assert property (
    wait_end |-> wcnt >= WAIT_MIN_CYC)
    else $error("wait too short");
  AST_WAIT_MAX: assert property (
    wait_end |-> wcnt <= WAIT_LONG_CYC + 8'h02)
    else $error("wait too long");
  AST_WAIT_SEL: assert property (
    wait_begin |-> !CARD_SELECT_N && !$past(CARD_SELECT_N, 2))
    else $error("wait without settled select");
  AST_RD_HOLD: assert property (
    CORE_REQ.rd_req && !CORE_RSP.rd_valid && !WAIT_N |=> !WAIT_N)
    else $error("wait ended before read data");
  AST_WR_HOLD: assert property (
    wr_pend && !CORE_RSP.wr_ack && !WAIT_N |=> !WAIT_N)
    else $error("wait ended before write taken");
  AST_IRQ_SET: assert property (
    CE && CORE_RSP.cmd_done |=> COMMAND_DONE_IRQ)
    else $error("interrupt not raised");
  AST_XREQ_SET: assert property (
    CE && CORE_RSP.buf_next |=> BUFFER_TRANSFER_REQUEST)
    else $error("data request not raised");
endmodule : hpw_host_port_assertions
bind hpw_host_port hpw_host_port_assertions u_chk (.REF_CLK, .RST_N, .CE,
  .CARD_SELECT_N, .READ_STROBE_N, .HOST_DATA_BUS_OE, .WAIT_N,
  .COMMAND_DONE_IRQ, .BUFFER_TRANSFER_REQUEST, .CORE_REQ, .CORE_RSP);
`default_nettype wire

// File: hpw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hpw_host_model (
  input wire logic clk, // Port clock.
  input wire logic wait_n, // Wait from the port.
  input wire logic [7:0] rd_bus, // Read data from the port.
  output logic cs_n, // Card select, active low.
  output logic rd_n, // Read strobe, active low.
  output logic wr_n, // Write strobe, active low.
  output logic [2:0] adr, // Register address.
  output logic [7:0] dout, // Data lines from the host.
  output logic to // A wait never ended.
);
  // Idle host; nothing pulls the data lines, so released ones invert.
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    adr = 3'h0;
    dout = 8'h00;
    to = 1'b0;
  end
  // One byte per select; all lines stand until the wait has ended.
  task automatic acc(input logic wr, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q, output int w);
    int n;
    logic seen;
    n = 0;
    w = 0;
    seen = 1'b0;
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= wr;
    wr_n <= !wr;
    adr <= a;
    dout <= wr ? d : ~dout;
    while (!(seen && wait_n) && n < 400) begin
      @(posedge clk);
      w = w + int'(!wait_n);
      seen = seen | !wait_n;
      n++;
    end
    q = rd_bus;
    to = n >= 400;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    dout <= ~dout;
    repeat (3) @(posedge clk);
    #1;
  endtask : acc
endmodule : hpw_host_model
`default_nettype wire

// File: test_host_port_wait_handshake.sv
`timescale 1ns/1ps
`default_nettype none
module test_host_port_wait_handshake
  import hpw_pkg::*;
;
  logic clk, rst_n, cs_n, rd_n, wr_n, oe, wt, irq, xreq, hto, wp;
  logic ce = 1'b1;
  logic [2:0] adr;
  logic [7:0] hd, dq, q;
  hpw_task_t tf;
  hpw_core_req_t req;
  hpw_core_rsp_t rsp;
  int w, lat = 2, cnt = 0, ncmd = 0, n_checks = 0, fail_count = 0;
  wire logic [7:0] bus = oe ? dq : hd;
  hpw_host_port dut (.REF_CLK(clk), .RST_N(rst_n), .CE(ce),
    .CARD_SELECT_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .REGISTER_SELECT_LINES(adr), .HOST_DATA_BUS_IN(bus),
    .HOST_DATA_BUS_OUT(dq), .HOST_DATA_BUS_OE(oe), .WAIT_N(wt),
    .COMMAND_DONE_IRQ(irq), .BUFFER_TRANSFER_REQUEST(xreq), .TASK(tf),
    .CORE_REQ(req), .CORE_RSP(rsp));
  hpw_host_model host (.clk(clk), .wait_n(wt), .rd_bus(dq), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .adr(adr), .dout(hd), .to(hto));
  // Core stand-in answers after lat cycles, so waits can be stretched.
  always @(posedge clk) begin
    wp <= req.wr_strobe | (wp & !rsp.wr_ack);
    cnt <= ((req.rd_req | wp) & !rsp.rd_valid & !rsp.wr_ack) ? cnt + 1 : 0;
    rsp.rd_valid <= req.rd_req && cnt == lat;
    rsp.wr_ack <= wp && cnt == lat;
  end
  // Command strobes seen by the core; exactly one per command write.
  always @(posedge clk) begin
    if (req.cmd_strobe) begin
      ncmd <= ncmd + 1;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkw(input string nm, input int lo, hi, g);
    n_checks++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chkw
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic access(input logic wr, input logic [2:0] a,
      input logic [7:0] d);
    host.acc(wr, a, d, q, w);
    if (hto) begin
      fail_count++;
      results();
    end
  endtask : access
  // One-cycle core event: done when c is set, buffer ready otherwise.
  task automatic pulse(input logic c);
    @(posedge clk);
    rsp.cmd_done <= c;
    rsp.buf_next <= !c;
    @(posedge clk);
    rsp.cmd_done <= 1'b0;
    rsp.buf_next <= 1'b0;
    @(posedge clk);
    #1;
  endtask : pulse
  task automatic sc_reset();
    chk("precomp", RST_PRECOMP, tf.precomp);
    chk("count", RST_SEC_COUNT, tf.sec_count);
    chk("head", RST_ZERO, tf.size_drive_head);
    chk("flags", 8'h04, {5'h00, wt, irq, xreq});
  endtask : sc_reset
  task automatic sc_regs();
    for (int a = 1; a < 7; a++) begin
      access(1'b1, 3'(a), 8'(8'h90 + a));
      chkw("wait", 19, 60, w);
    end
    chk("precomp", 8'h91, tf.precomp);
    chk("cyl_high", 8'h95, tf.cyl_high);
    for (int a = 1; a < 8; a++) begin
      access(1'b0, 3'(a), 8'h00);
      chk("reg", (a == 1) ? 8'h04 : (a == 7) ? 8'h50 :
          8'(8'h90 + a), q);
    end
  endtask : sc_regs
  task automatic sc_data();
    lat = 40;
    access(1'b0, ADR_DATA, 8'h00);
    chk("rd", 8'h3c, q);
    chkw("rd wait", 40, 90, w);
    access(1'b1, ADR_DATA, 8'h6b);
    chk("wr", 8'h6b, req.wr_data);
    chkw("wr wait", 40, 90, w);
    lat = 2;
    pulse(1'b0);
    chk("xreq", 8'h01, {7'h00, xreq});
    access(1'b0, ADR_DATA, 8'h00);
    chk("xreq", 8'h00, {7'h00, xreq});
  endtask : sc_data
  task automatic sc_cmd();
    pulse(1'b1);
    chk("irq", 8'h01, {7'h00, irq});
    access(1'b0, ADR_STATUS_CMD, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    pulse(1'b1);
    access(1'b1, ADR_STATUS_CMD, 8'h20);
    chk("irq", 8'h00, {7'h00, irq});
    chk("cmd", 8'h20, req.cmd);
    chk("cmd strobes", 8'h01, 8'(ncmd));
    access(1'b0, ADR_SEC_NUMBER, 8'h00);
    chkw("first wait", 100, 160, w);
    access(1'b0, ADR_SEC_NUMBER, 8'h00);
    chkw("next wait", 19, 60, w);
  endtask : sc_cmd
  // Clock enable low freezes the flags, so a completion then is lost.
  task automatic sc_freeze();
    @(posedge clk);
    ce <= 1'b0;
    pulse(1'b1);
    chk("frozen irq", 8'h00, {7'h00, irq});
    @(posedge clk);
    ce <= 1'b1;
    pulse(1'b1);
    chk("irq", 8'h01, {7'h00, irq});
  endtask : sc_freeze
  // Clock of 40 ns period.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Reset for 12 cycles, then the scenarios in turn.
  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    rsp = '0;
    rsp.rd_data = 8'h3c;
    rsp.status = 8'h50;
    rsp.error = 8'h04;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    sc_reset();
    sc_regs();
    sc_data();
    sc_cmd();
    sc_freeze();
    results();
  end
endmodule : test_host_port_wait_handshake
`default_nettype wire
